// ==== hw/cmcm_link_if.sv ====
// Purpose: serial link joining the monitor end and the master end
// Assumes: data out is a plain push-pull line from the monitor
// Notes:   no clocking block; both ends sample on their own mclk
`timescale 1ns/100ps
`default_nettype none
interface cmcm_link_if;
	logic sclk;     // serial clock, made by the master
	logic csb_n;    // frame select, active low
	logic sdi;      // master to monitor
	logic sdo;      // monitor to master
	modport monitor (input sclk, input csb_n, input sdi, output sdo);
	modport master  (output sclk, output csb_n, output sdi, input sdo);
endinterface : cmcm_link_if
`default_nettype wire

// ==== hw/cmcm_master.sv ====
// Purpose: master end: sends a command, its check byte and data
// Assumes: software drives a one-cycle strobe port
// Notes:   sclk derived by a divider from mclk
`timescale 1ns/100ps
`default_nettype none
module cmcm_master
	import cmcm_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset_n,
	cmcm_link_if.master      link,
	input  wire logic [3:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [7:0]       rdata,
	output logic             irq
);
	logic [2:0] sdo_s;
	logic [7:0] div_reg, cnt_reg, tx_reg, rx_reg, sh_reg;
	logic [2:0] bit_reg;
	logic       busy_reg, sclk_reg, csb_reg, sdi_reg, hold_reg, tick;
	logic       armed_reg;
	logic [1:0] irq_st_reg, irq_en_reg;
	logic       byte_ev, poll_ev;

	// ------------------------------------------------------------------
	// data-out synchroniser and clock divider
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			sdo_s <= 3'h7;
		else
			sdo_s <= {sdo_s[1:0], link.sdo};
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			cnt_reg <= 8'h00;
		else if (tick || !busy_reg)
			cnt_reg <= 8'h00;
		else
			cnt_reg <= cnt_reg + 8'h01;
	end
	assign tick = busy_reg && cnt_reg == div_reg;

	// ------------------------------------------------------------------
	// byte engine: falling edge sets data, end of the high phase samples
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			busy_reg <= 1'b0;
			sclk_reg <= 1'b1;
			csb_reg  <= 1'b1;
			sdi_reg  <= 1'b0;
			sh_reg   <= 8'h00;
			rx_reg   <= 8'h00;
			bit_reg  <= 3'h0;
			armed_reg <= 1'b0;
		end else if (wr && addr == H_TXDATA && !busy_reg) begin
			busy_reg <= 1'b1;
			csb_reg  <= 1'b0;
			sh_reg   <= wdata;
			bit_reg  <= 3'h0;
			armed_reg <= 1'b0;
		end else if (wr && addr == H_CTRL && !busy_reg) begin
			csb_reg  <= ~wdata[0];
		end else if (tick && !sclk_reg) begin
			sclk_reg  <= 1'b1;
			armed_reg <= 1'b1;
		end else if (tick && armed_reg) begin
			// sample at the end of the high phase: the answer to a fall
			// needs about five mclk to cross both synchronisers
			rx_reg    <= {rx_reg[6:0], sdo_s[1]};
			bit_reg   <= bit_reg + 3'h1;
			armed_reg <= 1'b0;
			if (bit_reg == 3'h7)
				busy_reg <= 1'b0;
			else begin
				sclk_reg <= 1'b0;
				sdi_reg  <= sh_reg[7];
				sh_reg   <= sh_reg << 1;
			end
		end else if (tick) begin
			sclk_reg <= 1'b0;
			sdi_reg  <= sh_reg[7];
			sh_reg   <= sh_reg << 1;
		end
	end
	assign byte_ev = tick && sclk_reg && armed_reg && bit_reg == 3'h7;
	assign poll_ev = !csb_reg && !busy_reg && sdo_s[1] && !hold_reg;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			hold_reg <= 1'b1;
		else
			hold_reg <= sdo_s[1];
	end
	assign link.sclk  = sclk_reg;
	assign link.csb_n = csb_reg;
	assign link.sdi   = sdi_reg;

	// ------------------------------------------------------------------
	// software registers and interrupt; set wins over clear
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			div_reg    <= DIV_RESET;
			irq_en_reg <= 2'b00;
			irq_st_reg <= 2'b00;
		end else begin
			if (wr && addr == H_DIV)
				div_reg <= (wdata == 8'h00) ? 8'h01 : wdata;
			if (wr && addr == H_IRQ_EN)
				irq_en_reg <= wdata[1:0];
			irq_st_reg <= (irq_st_reg & ~((wr && addr == H_IRQ_CL)
				? wdata[1:0] : 2'b00)) | {poll_ev, byte_ev};
		end
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= 8'h00;
			irq   <= 1'b0;
		end else begin
			irq <= |(irq_st_reg & irq_en_reg);
			if (rd)
				case (addr)
					H_CTRL:   rdata <= {7'h00, ~csb_reg};
					H_STATUS: rdata <= {6'h00, sdo_s[1], busy_reg};
					H_TXDATA: rdata <= sh_reg;
					H_RXDATA: rdata <= rx_reg;
					H_IRQ_ST: rdata <= {6'h00, irq_st_reg};
					H_IRQ_EN: rdata <= {6'h00, irq_en_reg};
					H_DIV:    rdata <= div_reg;
					default:  rdata <= 8'h00;
				endcase
		end
	end
endmodule : cmcm_master
`default_nettype wire

// ==== hw/cmcm_monitor.sv ====
// Purpose: monitor end: decodes commands, serves register groups
// Assumes: link mode 3, bits taken on sclk rise, msb first
// Notes:   cell readings and flags come in from the analogue side
//
// Summary of operation
// - 0x20 all-cell open wire, 0x21-0x2C single
// - 0x30-0x33 temperature, 0x3E/0x3F self tests
// - 0x40 conversion poll, 0x50 alarm poll
// - 0x52 starts diagnose, 0x54 reads diagnostics
// - 0x60-0x6C conversions with discharge kept
// - 0x70-0x7C open wire with discharge kept
// - every command followed by its check byte
// - config byte 0 field order from bit 7
// - readings packed two per three bytes
// - ten-cell mode hides last three reading bytes
// - flags four cells per byte, under low
// - ten-cell mode forces cell 11/12 flags low; here only in the flag read, the alarm poll still sees them
// - level polling drives a level, not toggles
// - reading busy returns all ones
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module cmcm_monitor
	import cmcm_pkg::*;
(
	input  wire logic          mclk,
	input  wire logic          reset_n,
	cmcm_link_if.monitor       link,
	input  wire logic [143:0]  cell_values,
	input  wire logic [11:0]   cell_busy,
	input  wire logic [11:0]   cell_under,
	input  wire logic [11:0]   cell_over,
	input  wire logic [15:0]   diag_value,
	input  wire logic          adc_busy,
	output logic [7:0]         start_cmd,
	output logic               start_pulse,
	output logic [47:0]        config_out,
	output logic               sdo_reg_dbg
);
	typedef enum {CMCM_IDLE, CMCM_CMD, CMCM_CHK, CMCM_WR, CMCM_RD,
		CMCM_POLL, CMCM_DROP} cmcm_mstate_t;

	logic [2:0]  sclk_s, csb_s, sdi_s;
	logic        rise, fall, frame;
	logic [7:0]  shift_reg, cmd_reg, out_reg;
	logic [2:0]  bit_reg;
	logic [4:0]  idx_reg;
	logic [7:0]  cfg_reg [CFG_BYTES];
	logic        poll_tog_reg, sdo_reg;
	cmcm_mstate_t st_reg;
	logic        byte_done;
	logic [7:0]  rx_byte;
	logic [7:0]  cur_byte;

	// ------------------------------------------------------------------
	// pin synchronisers; only the second and third stage are read
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_s <= 3'h7;
			csb_s  <= 3'h7;
			sdi_s  <= 3'h0;
		end else begin
			sclk_s <= {sclk_s[1:0], link.sclk};
			csb_s  <= {csb_s[1:0], link.csb_n};
			sdi_s  <= {sdi_s[1:0], link.sdi};
		end
	end
	assign rise      = sclk_s[1] & ~sclk_s[2];
	assign fall      = ~sclk_s[1] & sclk_s[2];
	assign frame     = ~csb_s[1];
	assign rx_byte   = {shift_reg[6:0], sdi_s[1]};
	assign byte_done = frame & rise & (bit_reg == 3'h7);

	// reading as seen on the link: busy cells read all ones
	function automatic logic [11:0] reading(input logic [3:0] n);
		reading = cell_busy[n] ? READING_BUSY
			: cell_values[n*12 +: 12];
	endfunction : reading

	// byte k of the selected group, lowest first
	function automatic logic [7:0] group_byte(input logic [7:0] c,
		input logic [4:0] k);
		logic [3:0]  p;
		logic [11:0] a, b;
		logic [1:0]  r;
		logic [11:0] uv, ov;
		int          f;
		p  = 4'(k / 3);
		r  = 2'(k % 3);
		a  = reading(4'(p * 2));
		b  = reading(4'(p * 2 + 1));
		uv = cell_under;
		ov = cell_over;
		group_byte = 8'h00;
		if (cfg_reg[0][CFG0_TEN]) begin
			uv[11:10] = 2'b00;
			ov[11:10] = 2'b00;
		end
		if (c == CMD_READ_CFG) begin
			if (k < 5'(CFG_BYTES))
				group_byte = cfg_reg[k[2:0]];
		end else if (c == CMD_READ_CELLS) begin
			case (r)
				2'd0:    group_byte = a[7:0];
				2'd1:    group_byte = {b[3:0], a[11:8]};
				default: group_byte = b[11:4];
			endcase
		end else if (c == CMD_READ_FLAGS) begin
			for (f = 0; f < 4; f++) begin
				group_byte[2*f]   = uv[k[1:0]*4 + f];
				group_byte[2*f+1] = ov[k[1:0]*4 + f];
			end
		end else if (c == CMD_DIAG_READ) begin
			group_byte = k[0] ? diag_value[15:8] : diag_value[7:0];
		end
	endfunction : group_byte

	// number of bytes a read command returns
	function automatic logic [4:0] group_len(input logic [7:0] c,
		input logic ten);
		if (c == CMD_READ_CFG)
			group_len = 5'(CFG_BYTES);
		else if (c == CMD_READ_CELLS)
			group_len = ten ? 5'(CELL_BYTES10) : 5'(CELL_BYTES);
		else if (c == CMD_READ_FLAGS)
			group_len = 5'(FLAG_BYTES);
		else
			group_len = 5'(DIAG_BYTES);
	endfunction : group_len

	// group byte now due, shared by the load and its first bit
	always_comb cur_byte = group_byte(cmd_reg, idx_reg);

	// ------------------------------------------------------------------
	// command sequencer
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg      <= CMCM_IDLE;
			shift_reg   <= 8'h00;
			bit_reg     <= 3'h0;
			cmd_reg     <= 8'h00;
			idx_reg     <= 5'h00;
			start_cmd   <= 8'h00;
			start_pulse <= 1'b0;
		end else begin
			start_pulse <= 1'b0;
			if (!frame) begin
				st_reg  <= CMCM_CMD;
				bit_reg <= 3'h0;
				idx_reg <= 5'h00;
			end else begin
				if (rise) begin
					shift_reg <= rx_byte;
					bit_reg   <= bit_reg + 3'h1;
				end
				if (byte_done) begin
					case (st_reg)
						CMCM_CMD: begin
							cmd_reg <= rx_byte;
							st_reg  <= CMCM_CHK;
						end
						CMCM_CHK: begin
							// wrong or missing check byte drops frame
							if (check_byte(cmd_reg) == 8'h00 ||
								rx_byte != check_byte(cmd_reg))
								st_reg <= CMCM_DROP;
							else case (cmd_kind(cmd_reg))
								CMCM_CK_WRITE: st_reg <= CMCM_WR;
								CMCM_CK_READ:  st_reg <= CMCM_RD;
								CMCM_CK_POLL:  st_reg <= CMCM_POLL;
								default: begin
									start_cmd   <= cmd_reg;
									start_pulse <= 1'b1;
									st_reg      <= CMCM_POLL;
								end
							endcase
						end
						CMCM_WR, CMCM_RD: idx_reg <= idx_reg + 5'h01;
						default: st_reg <= st_reg;
					endcase
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// configuration group; bit 7 is a plain stored bit, reset low and written like the rest
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_reg[0] <= CFG0_RESET;
			for (int i = 1; i < CFG_BYTES; i++)
				cfg_reg[i] <= 8'h00;
		end else if (byte_done && st_reg == CMCM_WR &&
			idx_reg < 5'(CFG_BYTES)) begin
			cfg_reg[idx_reg[2:0]] <= rx_byte;
		end
	end
	assign config_out = {cfg_reg[5], cfg_reg[4], cfg_reg[3],
		cfg_reg[2], cfg_reg[1], cfg_reg[0]};

	// ------------------------------------------------------------------
	// data out: read shifter and poll response
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			out_reg      <= 8'h00;
			poll_tog_reg <= 1'b0;
			sdo_reg      <= 1'b1;
		end else if (!frame) begin
			poll_tog_reg <= 1'b0;
			sdo_reg      <= 1'b1;
		end else if (st_reg == CMCM_RD) begin
			if (fall && bit_reg == 3'h0) begin
				out_reg <= cur_byte << 1;
				sdo_reg <= (idx_reg < group_len(cmd_reg, cfg_reg[0][CFG0_TEN]))
					? cur_byte[7] : 1'b0;
			end else if (fall) begin
				out_reg <= out_reg << 1;
				sdo_reg <= (idx_reg < group_len(cmd_reg, cfg_reg[0][CFG0_TEN]))
					? out_reg[7] : 1'b0;
			end
		end else if (st_reg == CMCM_POLL) begin
			// busy reads low; toggle mode flips on each clock when idle
			if (cfg_reg[0][CFG0_LVLSEL])
				sdo_reg <= ~(cmd_reg == CMD_ALARM_POLL
					? |(cell_under | cell_over) : adc_busy);
			else if (fall) begin
				poll_tog_reg <= ~poll_tog_reg;
				sdo_reg <= (cmd_reg == CMD_ALARM_POLL
					? |(cell_under | cell_over) : adc_busy)
					? 1'b0 : ~poll_tog_reg;
			end
		end
	end
	assign link.sdo    = sdo_reg;
	assign sdo_reg_dbg = sdo_reg;
endmodule : cmcm_monitor
`default_nettype wire

// ==== hw/cmcm_pkg.sv ====
// Purpose: shared constants for the cell monitor command link
// Assumes: one-byte commands, each followed by a fixed check byte
// Notes:   link is a serial clock/select/data-in/data-out bus, msb first
package cmcm_pkg;
	// ------------------------------------------------------------------
	// command codes and check bytes
	// ------------------------------------------------------------------
	localparam logic [7:0] CMD_WRITE_CFG     = 8'h01;
	localparam logic [7:0] CMD_READ_CFG      = 8'h02;
	localparam logic [7:0] CMD_READ_CELLS    = 8'h04;
	localparam logic [7:0] CMD_READ_FLAGS    = 8'h0c;
	localparam logic [7:0] CMD_OPEN_WIRE_ALL = 8'h20;
	localparam logic [7:0] CMD_OPEN_WIRE_LST = 8'h2c;
	localparam logic [7:0] CMD_TEMP_ALL      = 8'h30;
	localparam logic [7:0] CMD_TEMP_INTERNAL = 8'h33;
	localparam logic [7:0] CMD_TEMP_TEST_1   = 8'h3e;
	localparam logic [7:0] CMD_TEMP_TEST_2   = 8'h3f;
	localparam logic [7:0] CMD_CONV_POLL     = 8'h40;
	localparam logic [7:0] CMD_ALARM_POLL    = 8'h50;
	localparam logic [7:0] CMD_DIAGNOSE      = 8'h52;
	localparam logic [7:0] CMD_DIAG_READ     = 8'h54;
	localparam logic [7:0] CMD_BAL_ALL       = 8'h60;
	localparam logic [7:0] CMD_BAL_LAST      = 8'h6c;
	localparam logic [7:0] CMD_OW_BAL_ALL    = 8'h70;
	localparam logic [7:0] CMD_OW_BAL_LAST   = 8'h7c;
	// ------------------------------------------------------------------
	// register group layout
	// ------------------------------------------------------------------
	localparam int CFG_BYTES   = 6;
	localparam int CELL_BYTES  = 18;
	localparam int CELL_BYTES10 = 15;
	localparam int FLAG_BYTES  = 3;
	localparam int DIAG_BYTES  = 2;
	localparam int CFG0_WDT    = 7;
	localparam int CFG0_GPIO2  = 6;
	localparam int CFG0_GPIO1  = 5;
	localparam int CFG0_LVLSEL = 4;
	localparam int CFG0_TEN    = 3;
	localparam logic [7:0] CFG0_RESET = 8'h60;
	localparam logic [11:0] READING_BUSY = 12'hfff;
	// ------------------------------------------------------------------
	// host register map (word index on the software port)
	// ------------------------------------------------------------------
	localparam logic [3:0] H_CTRL   = 4'h0;
	localparam logic [3:0] H_STATUS = 4'h1;
	localparam logic [3:0] H_TXDATA = 4'h2;
	localparam logic [3:0] H_RXDATA = 4'h3;
	localparam logic [3:0] H_IRQ_ST = 4'h4;
	localparam logic [3:0] H_IRQ_EN = 4'h5;
	localparam logic [3:0] H_IRQ_CL = 4'h6;
	localparam logic [3:0] H_DIV    = 4'h7;
	localparam logic [7:0] DIV_RESET = 8'h04;

	typedef enum logic [2:0] {
		CMCM_CK_NONE, CMCM_CK_WRITE, CMCM_CK_READ, CMCM_CK_POLL,
		CMCM_CK_START
	} cmcm_kind_t;

	// pairs a command with its fixed check byte; zero marks unknown
	function automatic logic [7:0] check_byte(input logic [7:0] c);
		case (c)
			8'h01: check_byte = 8'hc7;  8'h02: check_byte = 8'hce;
			8'h04: check_byte = 8'hdc;  8'h0c: check_byte = 8'he4;
			8'h20: check_byte = 8'h20;  8'h21: check_byte = 8'h27;
			8'h22: check_byte = 8'h2e;  8'h23: check_byte = 8'h29;
			8'h24: check_byte = 8'h3c;  8'h25: check_byte = 8'h3b;
			8'h26: check_byte = 8'h32;  8'h27: check_byte = 8'h35;
			8'h28: check_byte = 8'h18;  8'h29: check_byte = 8'h1f;
			8'h2a: check_byte = 8'h16;  8'h2b: check_byte = 8'h11;
			8'h2c: check_byte = 8'h04;  8'h30: check_byte = 8'h50;
			8'h31: check_byte = 8'h57;  8'h32: check_byte = 8'h5e;
			8'h33: check_byte = 8'h59;  8'h3e: check_byte = 8'h7a;
			8'h3f: check_byte = 8'h7d;  8'h40: check_byte = 8'h07;
			8'h50: check_byte = 8'h77;  8'h52: check_byte = 8'h79;
			8'h54: check_byte = 8'h6b;  8'h60: check_byte = 8'he7;
			8'h61: check_byte = 8'he0;  8'h62: check_byte = 8'he9;
			8'h63: check_byte = 8'hee;  8'h64: check_byte = 8'hfb;
			8'h65: check_byte = 8'hfc;  8'h66: check_byte = 8'hf5;
			8'h67: check_byte = 8'hf2;  8'h68: check_byte = 8'hdf;
			8'h69: check_byte = 8'hd8;  8'h6a: check_byte = 8'hd1;
			8'h6b: check_byte = 8'hd6;  8'h6c: check_byte = 8'hc3;
			8'h70: check_byte = 8'h97;  8'h71: check_byte = 8'h90;
			8'h72: check_byte = 8'h99;  8'h73: check_byte = 8'h9e;
			8'h74: check_byte = 8'h8b;  8'h75: check_byte = 8'h8c;
			8'h76: check_byte = 8'h85;  8'h77: check_byte = 8'h82;
			8'h78: check_byte = 8'haf;  8'h79: check_byte = 8'ha8;
			8'h7a: check_byte = 8'ha1;  8'h7b: check_byte = 8'ha6;
			8'h7c: check_byte = 8'hb3;
			default: check_byte = 8'h00;
		endcase
	endfunction : check_byte

	// sorts a command into the kind of transfer that follows it
	function automatic cmcm_kind_t cmd_kind(input logic [7:0] c);
		if (c == CMD_WRITE_CFG)
			cmd_kind = CMCM_CK_WRITE;
		else if (c == CMD_READ_CFG || c == CMD_READ_CELLS ||
			c == CMD_READ_FLAGS || c == CMD_DIAG_READ)
			cmd_kind = CMCM_CK_READ;
		else if (c == CMD_CONV_POLL || c == CMD_ALARM_POLL)
			cmd_kind = CMCM_CK_POLL;
		else if (check_byte(c) != 8'h00)
			cmd_kind = CMCM_CK_START;
		else
			cmd_kind = CMCM_CK_NONE;
	endfunction : cmd_kind
endpackage : cmcm_pkg

// ==== testbench/cell_monitor_command_map_test.sv ====
// Purpose: bench joining master and monitor ends over the link
// Assumes: default divider; the bench plays the analogue side
// Notes:   reads and starts are queued, then checked by a watcher
`timescale 1ns/100ps
`default_nettype none
module cell_monitor_command_map_test
	import cmcm_pkg::*;
;
	// ----------------------------------------------------------------
	// signals, instances, watchers
	// ----------------------------------------------------------------
	logic         mclk, reset_n, wr, rd, irq, adc_busy, start_pulse;
	logic         rd_seen;
	logic [3:0]   addr;
	logic [7:0]   wdata, rdata, start_cmd, last_rd, sh, c;
	logic [143:0] cell_values;
	logic [11:0]  cell_busy, cell_under, cell_over, a, b;
	logic [15:0]  diag_value;
	logic [47:0]  config_out;
	logic [8:0]   e;
	logic [8:0]   rd_q[$];
	logic [7:0]   st_q[$], codes[$], exp_b[18], cfg[6];
	int           err_count, comparisons;

	cmcm_link_if link ();
	cmcm_monitor cmcm_monitor_i (.mclk(mclk), .reset_n(reset_n),
		.link(link.monitor), .cell_values(cell_values),
		.cell_busy(cell_busy), .cell_under(cell_under),
		.cell_over(cell_over), .diag_value(diag_value),
		.adc_busy(adc_busy), .start_cmd(start_cmd),
		.start_pulse(start_pulse), .config_out(config_out),
		.sdo_reg_dbg());
	cmcm_master cmcm_master_i (.mclk(mclk), .reset_n(reset_n),
		.link(link.master), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .irq(irq));
	cmcm_link_assertions cmcm_link_assertions_i (.mclk(mclk),
		.reset_n(reset_n), .sclk(link.sclk), .csb_n(link.csb_n),
		.sdi(link.sdi), .sdo(link.sdo), .start_cmd(start_cmd),
		.start_pulse(start_pulse));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// bits as the monitor takes them, on the sclk rise
	always @(posedge link.sclk)
		if (!link.csb_n) sh <= {sh[6:0], link.sdi};
	// read data is valid from the cycle after the strobe
	always @(posedge mclk) rd_seen <= rd;
	always @(negedge mclk) begin
		if (rd_seen) begin
			last_rd = rdata;
			e = rd_q.pop_front();
			if (e[8]) check(rdata, e[7:0]);
		end
		if (start_pulse)
			check(start_cmd, st_q.size() ? st_q.pop_front() : 8'h00);
	end
	// hang guard, well past the expected run length
	initial begin
		repeat (80000) @(posedge mclk);
		err_count++;
		final_report();
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	// packet check: crc-8, poly 0x07, seed 0x41
	function automatic logic [7:0] packet_check_byte(input logic [7:0] x);
		logic [7:0] r;
		r = 8'h41 ^ x;
		for (int i = 0; i < 8; i++)
			r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
		return r;
	endfunction : packet_check_byte
	task automatic wr_reg(input logic [3:0] ad, input logic [7:0] d);
		@(posedge mclk);
		addr  <= ad;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg
	// bit 8 of the note asks for a compare, else just capture
	task automatic rd_reg(input logic [3:0] ad, input logic [8:0] ex);
		@(posedge mclk);
		addr <= ad;
		rd   <= 1'b1;
		rd_q.push_back(ex);
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		#1;
	endtask : rd_reg
	task automatic settle();
		repeat (3) @(posedge mclk);
		#1;
	endtask : settle
	task automatic xfer(input logic [7:0] d);
		int n;
		wr_reg(H_TXDATA, d);
		@(posedge mclk);
		n = 0;
		do begin
			rd_reg(H_STATUS, 9'h000);
			n++;
		end while (last_rd[0] && n < 200);
		if (n >= 200) check(1, 0);
	endtask : xfer
	task automatic frame(input logic [7:0] cm, input logic [7:0] k);
		wr_reg(H_CTRL, 8'h01);
		xfer(cm);
		check(sh, cm);
		xfer(k);
	endtask : frame
	task automatic end_frame();
		wr_reg(H_CTRL, 8'h00);
		repeat (10) @(posedge mclk);
	endtask : end_frame
	task automatic wr_cfg();
		frame(CMD_WRITE_CFG, packet_check_byte(CMD_WRITE_CFG));
		foreach (cfg[i]) xfer(cfg[i]);
		end_frame();
	endtask : wr_cfg
	task automatic read_group(input logic [7:0] cm, input int n);
		frame(cm, packet_check_byte(cm));
		for (int i = 0; i < n; i++) begin
			xfer(8'h00);
			rd_reg(H_RXDATA, {1'b1, exp_b[i]});
		end
		end_frame();
	endtask : read_group
	task automatic final_report();
		if (err_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		{wr, rd, adc_busy, addr, wdata} = '0;
		{cell_values, cell_busy, cell_under, cell_over} = '0;
		diag_value = 16'h0000;
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		void'($urandom(32'hdd02518f));
		check({link.sclk, link.csb_n, link.sdo}, 3'b111);
		rd_reg(4'hf, 9'h100);
		rd_reg(H_DIV, {1'b1, DIV_RESET});
		exp_b = '{default: 8'h00};
		exp_b[0] = CFG0_RESET;
		read_group(CMD_READ_CFG, CFG_BYTES);
		// twelve-cell pass, then ten-cell pass
		for (int t = 0; t < 2; t++) begin
			foreach (cfg[i]) cfg[i] = 8'($urandom);
			cfg[0][4:3] = {1'b0, t[0]};
			cfg[2][7:4] = 4'h0;
			cfg[3] = 8'h00;
			wr_cfg();
			check(config_out, {cfg[5], cfg[4], cfg[3], cfg[2], cfg[1],
				cfg[0]});
			foreach (cfg[i]) exp_b[i] = cfg[i];
			read_group(CMD_READ_CFG, CFG_BYTES);
			@(posedge mclk);
			for (int i = 0; i < 12; i++)
				cell_values[i*12+:12] <= 12'($urandom);
			cell_busy  <= 12'h020;
			cell_under <= 12'($urandom);
			cell_over  <= 12'($urandom);
			@(posedge mclk);
			for (int p = 0; p < 6; p++) begin
				a = cell_busy[2*p] ? 12'hfff : cell_values[24*p+:12];
				b = cell_busy[2*p+1] ? 12'hfff : cell_values[24*p+12+:12];
				exp_b[3*p]   = a[7:0];
				exp_b[3*p+1] = {b[3:0], a[11:8]};
				exp_b[3*p+2] = b[11:4];
			end
			if (t) for (int i = 15; i < 18; i++) exp_b[i] = 8'h00;
			read_group(CMD_READ_CELLS, CELL_BYTES);
			for (int k = 0; k < 12; k++)
				exp_b[k/4][2*(k%4)+:2] = (t && k > 9) ? 2'b00
					: {cell_over[k], cell_under[k]};
			read_group(CMD_READ_FLAGS, FLAG_BYTES);
		end
		// every start code, each with its own check byte
		codes = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h3e, 8'h3f, 8'h52};
		for (int i = 0; i < 13; i++) begin
			codes.push_back(8'h20 + 8'(i));
			codes.push_back(8'h60 + 8'(i));
			codes.push_back(8'h70 + 8'(i));
		end
		foreach (codes[i]) begin
			st_q.push_back(codes[i]);
			frame(codes[i], packet_check_byte(codes[i]));
			end_frame();
		end
		// wrong check byte: no start, and data out stays high
		frame(CMD_BAL_ALL, packet_check_byte(CMD_BAL_ALL) ^ 8'h01);
		xfer(8'h00);
		check(link.sdo, 1'b1);
		rd_reg(H_RXDATA, 9'h1ff);
		end_frame();
		// level polling: busy and alarm pull data out low
		cfg[0][4:3] = 2'b10;
		wr_cfg();
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			adc_busy   <= (i == 0);
			cell_under <= {11'h000, i == 2};
			cell_over  <= 12'h000;
			c = (i < 2) ? CMD_CONV_POLL : CMD_ALARM_POLL;
			frame(c, packet_check_byte(c));
			repeat (8) @(posedge mclk);
			rd_reg(H_STATUS, 9'h000);
			check(last_rd[1], i[0]);
			end_frame();
		end
		// toggle polling: low while busy, alternating when idle
		cfg[0][4] = 1'b0;
		wr_cfg();
		for (int i = 0; i < 2; i++) begin
			@(posedge mclk);
			adc_busy <= (i == 0);
			frame(CMD_CONV_POLL, packet_check_byte(CMD_CONV_POLL));
			xfer(8'h00);
			rd_reg(H_RXDATA, 9'h000);
			check(i ? last_rd inside {8'h55, 8'haa} : last_rd === 8'h00,
				1'b1);
			end_frame();
		end
		@(posedge mclk);
		diag_value <= 16'($urandom);
		@(posedge mclk);
		exp_b[0] = diag_value[7:0];
		exp_b[1] = diag_value[15:8];
		read_group(CMD_DIAG_READ, DIAG_BYTES);
		// byte-done interrupt: raise, mask, unmask, clear
		wr_reg(H_IRQ_CL, 8'hff);
		wr_reg(H_IRQ_EN, 8'h01);
		settle();
		check(irq, 1'b0);
		wr_reg(H_CTRL, 8'h01);
		xfer(8'h00);
		settle();
		check(irq, 1'b1);
		rd_reg(H_IRQ_ST, 9'h000);
		check(last_rd[0], 1'b1);
		wr_reg(H_IRQ_EN, 8'h00);
		settle();
		check(irq, 1'b0);
		wr_reg(H_IRQ_EN, 8'h01);
		settle();
		check(irq, 1'b1);
		wr_reg(H_IRQ_CL, 8'h01);
		settle();
		check(irq, 1'b0);
		end_frame();
		check(st_q.size(), 0);
		final_report();
	end
endmodule : cell_monitor_command_map_test
`default_nettype wire

// ==== testbench/cmcm_link_assertions.sv ====
// Purpose: wire and start checks for the cell monitor command link
// Assumes: default divider, so each sclk phase spans five mclk
// Notes:   watches the link and the monitor start outputs only
`timescale 1ns/100ps
`default_nettype none
module cmcm_link_assertions (
	input wire logic       mclk,
	input wire logic       reset_n,
	input wire logic       sclk,
	input wire logic       csb_n,
	input wire logic       sdi,
	input wire logic       sdo,
	input wire logic [7:0] start_cmd,
	input wire logic       start_pulse
);
	// ----------------------------------------------------------------
	// link framing and start decode
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// clock parks high between frames
	idle_clock_a: assert property (
		csb_n && $past(csb_n) |-> sclk && $stable(sclk))
		else $error("sclk moved outside a frame");
	// data out returns high once the frame has ended
	sdo_idle_a: assert property (csb_n [*8] |-> sdo)
		else $error("sdo not idle high");
	start_width_a: assert property (start_pulse |=> !start_pulse)
		else $error("start pulse longer than one cycle");
	// the held command only moves together with a start
	cmd_hold_a: assert property ($changed(start_cmd) |-> start_pulse)
		else $error("start command changed without a start");
	cmd_legal_a: assert property (start_pulse |-> start_cmd inside {
		[8'h20:8'h2c], [8'h30:8'h33], 8'h3e, 8'h3f, 8'h52,
		[8'h60:8'h6c], [8'h70:8'h7c]})
		else $error("start for a code that starts nothing");
	low_phase_a: assert property ($fell(sclk) |-> !sclk [*4])
		else $error("sclk low phase too short");
	high_phase_a: assert property (
		$rose(sclk) && !csb_n |-> sclk [*4])
		else $error("sclk high phase too short");
	fall_bound_a: assert property ($fell(sclk) |-> ##[1:8] $rose(sclk))
		else $error("sclk stuck low");
	// master data must not move while the monitor samples it
	sdi_hold_a: assert property ($rose(sclk) |=> $stable(sdi) [*3])
		else $error("sdi moved after sclk rise");
	sdo_hold_a: assert property (
		$rose(sclk) && !csb_n |-> $stable(sdo))
		else $error("sdo moved at sclk rise");

	cover property (start_pulse && start_cmd == 8'h7c);
	cover property ($fell(csb_n));
	cover property (!csb_n && !sdo);
endmodule : cmcm_link_assertions
`default_nettype wire
